// File: inc/fra_pkg.sv
// package: constants for the i2c register access block
package fra_pkg;
  // i2c device addresses (8-bit form, r/w bit included)
  localparam logic [7:0] FRA_ADDR_WR      = 8'h86;
  localparam logic [7:0] FRA_ADDR_RD      = 8'h87;
  // register subaddresses
  localparam logic [7:0] FRA_SUB_MAKER    = 8'h00;
  localparam logic [7:0] FRA_SUB_STATUS   = 8'h35;
  localparam logic [7:0] FRA_SUB_RD_ADDR  = 8'h36;
  localparam logic [7:0] FRA_SUB_WR_ADDR  = 8'h37;
  localparam logic [7:0] FRA_SUB_DATA     = 8'h38;
  localparam logic [7:0] FRA_SUB_PADS     = 8'hf2;
  // field positions and reset values
  localparam int         FRA_BUSY_BIT     = 2;
  localparam logic [7:0] FRA_PADS_RESET   = 8'h00;
  localparam logic [7:0] FRA_ZERO_BYTE    = 8'h00;
  // arbitrary maker code, not tied to any real part
  localparam logic [7:0] FRA_MAKER_ID     = 8'h5a;
  // internal processor ram cycle latency in clocks
  localparam logic [3:0] FRA_RAM_LATENCY  = 4'h8;
  localparam logic [2:0] FRA_BIT_LAST     = 3'h7;

  typedef enum logic [6:0] {
    FRA_IDLE  = 7'b000_0001,
    FRA_DEVA  = 7'b000_0010,
    FRA_ACK   = 7'b000_0100,
    FRA_WRB   = 7'b000_1000,
    FRA_RDB   = 7'b001_0000,
    FRA_RACK  = 7'b010_0000,
    FRA_SKIP  = 7'b100_0000
  } fra_state_t;
endpackage

// File: hw/fra_ram.sv
// internal processor ram with busy-timed indirect access
`timescale 1ns/1ps
module fra_ram #(
  parameter int AW = 6
) (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_b_i,
  // request
  input  wire logic                        rd_req_i,
  input  wire logic                        wr_req_i,
  input  wire logic [15:0]                 addr_i,
  input  wire logic [15:0]                 wdata_i,
  // answer
  output logic      [15:0]                 rdata_o,
  output logic                             busy_o
);
  import fra_pkg::*;
  logic [15:0] mem [2**AW];
  logic [15:0] next_mem [2**AW];
  logic [3:0]  cnt, next_cnt;
  logic        is_rd, next_is_rd;
  logic [15:0] addr_q, next_addr_q, wd_q, next_wd_q, next_rdata;

  always_comb begin
    next_mem   = mem;
    next_cnt   = cnt;
    next_is_rd = is_rd;
    next_addr_q = addr_q;
    next_wd_q  = wd_q;
    next_rdata = rdata_o;
    if (cnt != 4'h0) begin
      next_cnt = cnt - 4'h1;
      if (cnt == 4'h1) begin
        if (is_rd) next_rdata = mem[addr_q[AW-1:0]];
        else next_mem[addr_q[AW-1:0]] = wd_q;
      end
    end else if (rd_req_i || wr_req_i) begin
      // new request only accepted when idle; host polls busy first
      next_cnt    = FRA_RAM_LATENCY;
      next_is_rd  = rd_req_i;
      next_addr_q = addr_i;
      next_wd_q   = wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < 2**AW; i++) mem[i] <= 16'h0000;
      cnt     <= 4'h0;
      is_rd   <= 1'b0;
      addr_q  <= 16'h0000;
      wd_q    <= 16'h0000;
      rdata_o <= 16'h0000;
      busy_o  <= 1'b0;
    end else begin
      mem     <= next_mem;
      cnt     <= next_cnt;
      is_rd   <= next_is_rd;
      addr_q  <= next_addr_q;
      wd_q    <= next_wd_q;
      rdata_o <= next_rdata;
      busy_o  <= (next_cnt != 4'h0);
    end
  end
endmodule

// File: hw/fra_top.sv
// i2c slave giving direct and indirect register access
`timescale 1ns/1ps
module fra_top #(
  parameter int RAM_AW = 6
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // i2c pins, synchronous samples
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_oe_b_o,
  // pad enable register contents
  output logic [7:0] output_pad_enables_o
);
  import fra_pkg::*;

  // ==========================================================
  // pin edges
  logic scl_q, sda_q;
  logic start_c, stop_c, rise_c, fall_c;
  assign start_c = scl_i && scl_q && sda_q && !sda_i;
  assign stop_c  = scl_i && scl_q && !sda_q && sda_i;
  assign rise_c  = scl_i && !scl_q;
  assign fall_c  = !scl_i && scl_q;

  // ==========================================================
  // protocol state
  fra_state_t  st, next_st;
  logic [7:0]  shf, next_shf;
  logic [2:0]  bcnt, next_bcnt;
  logic [7:0]  sub, next_sub;
  logic        have_sub, next_have_sub;
  logic        hi, next_hi;
  logic [7:0]  hold, next_hold;
  logic [15:0] raddr, next_raddr, waddr, next_waddr;
  logic [7:0]  pads, next_pads;
  logic        oe_b, next_oe_b;
  logic        rd_req, wr_req, next_rd_req, next_wr_req;
  logic [15:0] req_addr, next_req_addr, req_data, next_req_data;
  logic [15:0] ram_rdata;
  logic        ram_busy;
  // byte-complete flag kept apart from the count, so a 00 byte still ends
  logic        byte_rdy, next_byte_rdy;
  // read direction latched from the address byte, never from data contents
  logic        rd_mode, next_rd_mode;

  // read value per subaddress; data port gives msb first
  function automatic logic [7:0] rd_byte(input logic [7:0] s, input logic h,
                                         input logic [15:0] d, input logic b,
                                         input logic [7:0] p);
    unique case (s)
      FRA_SUB_MAKER:  rd_byte = FRA_MAKER_ID;
      FRA_SUB_STATUS: rd_byte = {5'h00, b, 2'h0};
      FRA_SUB_DATA:   rd_byte = h ? d[15:8] : d[7:0];
      FRA_SUB_PADS:   rd_byte = p;
      default:        rd_byte = FRA_ZERO_BYTE;
    endcase
  endfunction

  always_comb begin
    next_st       = st;
    next_shf      = shf;
    next_bcnt     = bcnt;
    next_sub      = sub;
    next_have_sub = have_sub;
    next_hi       = hi;
    next_hold     = hold;
    next_raddr    = raddr;
    next_waddr    = waddr;
    next_pads     = pads;
    next_oe_b     = oe_b;
    next_rd_req   = 1'b0;
    next_wr_req   = 1'b0;
    next_req_addr = req_addr;
    next_req_data = req_data;
    next_byte_rdy = byte_rdy;
    next_rd_mode  = rd_mode;
    if (stop_c) begin
      // stop ends any transfer
      next_st   = FRA_IDLE;
      next_oe_b = 1'b1;
    end else if (start_c) begin
      // repeated start keeps subaddress for the read phase
      next_st   = FRA_DEVA;
      next_bcnt = 3'h0;
      next_oe_b = 1'b1;
      next_hi   = 1'b1;
      next_shf  = FRA_ZERO_BYTE;
      // bits clocked before a repeated start must not complete a byte
      next_byte_rdy = 1'b0;
    end else begin
      unique case (st)
        FRA_IDLE: ;
        FRA_DEVA, FRA_WRB: begin
          if (rise_c) begin
            next_shf      = {shf[6:0], sda_i};
            next_bcnt     = bcnt + 3'h1;
            next_byte_rdy = (bcnt == FRA_BIT_LAST);
          end
          if (fall_c && byte_rdy) begin
            // full byte received, decide ack
            next_byte_rdy = 1'b0;
            if (st == FRA_DEVA) begin
              if (shf == FRA_ADDR_WR) begin
                next_st       = FRA_ACK;
                next_oe_b     = 1'b0;
                next_have_sub = 1'b0;
                next_rd_mode  = 1'b0;
              end else if (shf == FRA_ADDR_RD) begin
                next_st      = FRA_ACK;
                next_oe_b    = 1'b0;
                next_rd_mode = 1'b1;
              end else begin
                next_st = FRA_SKIP;
              end
            end else begin
              next_st   = FRA_ACK;
              next_oe_b = 1'b0;
              if (!have_sub) begin
                next_sub = shf; next_have_sub = 1'b1; next_hi = 1'b1;
              end else begin
                unique case (sub)
                  FRA_SUB_PADS: next_pads = shf;
                  FRA_SUB_RD_ADDR: begin
                    if (hi) next_raddr[15:8] = shf;
                    else begin
                      next_raddr[7:0] = shf;
                      next_rd_req     = 1'b1;
                      next_req_addr   = {raddr[15:8], shf};
                    end
                  end
                  FRA_SUB_WR_ADDR: begin
                    if (hi) next_waddr[15:8] = shf;
                    else next_waddr[7:0] = shf;
                  end
                  FRA_SUB_DATA: begin
                    if (hi) next_hold = shf;
                    else begin
                      next_wr_req   = 1'b1;
                      next_req_addr = waddr;
                      next_req_data = {hold, shf};
                    end
                  end
                  default: ;
                endcase
                next_hi = !hi;
              end
            end
          end
        end
        FRA_ACK: begin
          if (fall_c) begin
            next_oe_b = 1'b1;
            next_bcnt = 3'h0;
            next_shf  = FRA_ZERO_BYTE;
            if (!rd_mode) begin
              next_st = FRA_WRB;
            end else if (!have_sub) begin
              next_st = FRA_SKIP;
            end else begin
              next_st   = FRA_RDB;
              next_shf  = rd_byte(sub, hi, ram_rdata, ram_busy, pads);
              next_oe_b = next_shf[FRA_BIT_LAST];
            end
          end
        end
        FRA_RDB: begin
          if (fall_c) begin
            next_shf  = {shf[6:0], 1'b0};
            next_bcnt = bcnt + 3'h1;
            next_oe_b = (bcnt == FRA_BIT_LAST) ? 1'b1 : shf[6];
            if (bcnt == FRA_BIT_LAST) begin
              next_st = FRA_RACK;
              next_hi = !hi;
            end
          end
        end
        FRA_RACK: begin
          if (rise_c) begin
            // master nack ends the read
            if (sda_i) next_st = FRA_SKIP;
            else begin
              next_st   = FRA_ACK;
              next_shf  = FRA_ADDR_RD;
            end
          end
        end
        FRA_SKIP: ;
        default: next_st = FRA_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    // slave live straight out of reset, no init lockout
    if (!rst_b_i) begin
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      st       <= FRA_IDLE;
      shf      <= FRA_ZERO_BYTE;
      bcnt     <= 3'h0;
      sub      <= FRA_ZERO_BYTE;
      have_sub <= 1'b0;
      hi       <= 1'b1;
      hold     <= FRA_ZERO_BYTE;
      raddr    <= 16'h0000;
      waddr    <= 16'h0000;
      pads     <= FRA_PADS_RESET;
      oe_b     <= 1'b1;
      rd_req   <= 1'b0;
      wr_req   <= 1'b0;
      req_addr <= 16'h0000;
      req_data <= 16'h0000;
      byte_rdy <= 1'b0;
      rd_mode  <= 1'b0;
    end else begin
      scl_q    <= scl_i;
      sda_q    <= sda_i;
      st       <= next_st;
      shf      <= next_shf;
      bcnt     <= next_bcnt;
      sub      <= next_sub;
      have_sub <= next_have_sub;
      hi       <= next_hi;
      hold     <= next_hold;
      raddr    <= next_raddr;
      waddr    <= next_waddr;
      pads     <= next_pads;
      oe_b     <= next_oe_b;
      rd_req   <= next_rd_req;
      wr_req   <= next_wr_req;
      req_addr <= next_req_addr;
      req_data <= next_req_data;
      byte_rdy <= next_byte_rdy;
      rd_mode  <= next_rd_mode;
    end
  end

  assign sda_oe_b_o           = oe_b;
  assign output_pad_enables_o = pads;

  // ==========================================================
  // internal processor ram
  fra_ram #(.AW(RAM_AW)) u_ram (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .rd_req_i(rd_req),
    .wr_req_i(wr_req),
    .addr_i  (req_addr),
    .wdata_i (req_data),
    .rdata_o (ram_rdata),
    .busy_o  (ram_busy)
  );
endmodule

// File: tb/fra_top_assertions.sv
// checker: concurrent assertions on the pins of the i2c register block
`timescale 1ns/1ps
module fra_top_assertions
  import fra_pkg::*;
#(
  parameter int RAM_AW = 6
) (
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_oe_b_o,
  input wire logic [7:0] output_pad_enables_o
);
  // ============================================================
  // sequences
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence scl_high_s; scl_i && $past(scl_i); endsequence
  sequence start_s; scl_high_s ##0 $fell(sda_i); endsequence
  sequence stop_s; scl_high_s ##0 $rose(sda_i); endsequence
  // ============================================================
  // assertions
  a_reset_outputs_idle: assert property (disable iff (1'b0) !rst_b_i |=>
    sda_oe_b_o && output_pad_enables_o == FRA_PADS_RESET)
    else $error("outputs not idle after reset");
  a_drive_after_fall: assert property ($changed(sda_oe_b_o) |->
    $past(scl_i, 2) && !$past(scl_i))
    else $error("sda drive changed off the clock fall");
  a_ack_holds_low: assert property ($fell(sda_oe_b_o) |=> !sda_oe_b_o [*2])
    else $error("low drive too short");
  a_drive_stable_high: assert property (scl_high_s |-> $stable(sda_oe_b_o))
    else $error("sda drive moved while clock high");
  a_start_released: assert property (start_s |-> sda_oe_b_o)
    else $error("line driven at start");
  a_stop_released: assert property (stop_s |=> sda_oe_b_o [*8])
    else $error("line driven after stop");
  a_pads_at_ack: assert property ($changed(output_pad_enables_o) |-> !sda_oe_b_o)
    else $error("pads changed outside acknowledge");
  a_pads_quiet_high: assert property (scl_high_s |-> $stable(output_pad_enables_o))
    else $error("pads changed while clock high");
endmodule

bind fra_top fra_top_assertions #(.RAM_AW(RAM_AW)) i_fra_top_assertions (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_oe_b_o(sda_oe_b_o), .output_pad_enables_o(output_pad_enables_o));

// File: tb/fra_host.sv
// i2c host model driving the register block's pins
`timescale 1ns/1ps
module fra_host
  import fra_pkg::*;
(
  // clock
  input  wire logic clk_i,
  // i2c wire
  input  wire logic sda_oe_b_i,
  output logic      scl_o,
  output logic      sda_o
);
  // ============================================================
  // wire and bit timing
  logic sda_drv = 1'b1;
  logic ack_a;
  logic s;
  initial scl_o = 1'b1;
  // pull-up: a released line reads high
  assign sda_o = sda_drv & sda_oe_b_i;
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // four clocks a phase, above the three-clock minimum
  task automatic bt(input logic d, output logic r);
    scl_o = 1'b0;
    tk(2);
    sda_drv = d;
    tk(2);
    scl_o = 1'b1;
    tk(2);
    r = sda_o;
    tk(2);
  endtask
  task automatic st();
    bt(1'b1, s);
    sda_drv = 1'b0;
    tk(4);
  endtask
  task automatic sp();
    bt(1'b0, s);
    sda_drv = 1'b1;
    tk(4);
  endtask
  task automatic wb(input logic [7:0] b, output logic a);
    for (int i = 7; i >= 0; i--) bt(b[i], s);
    bt(1'b1, s);
    a = !s;
  endtask
  // ============================================================
  // transactions
  task automatic wr(input logic [7:0] dev, input logic [7:0] sub, input logic [7:0] q[$]);
    st();
    wb(dev, ack_a);
    wb(sub, s);
    foreach (q[i]) wb(q[i], s);
    sp();
  endtask
  task automatic rd(input logic [7:0] sub, input int n, output logic [7:0] q[$]);
    q = {};
    st();
    wb(FRA_ADDR_WR, s);
    wb(sub, s);
    st();
    wb(FRA_ADDR_RD, s);
    for (int i = 0; i < n; i++) begin
      logic [7:0] b;
      for (int j = 7; j >= 0; j--) bt(1'b1, b[j]);
      bt(i == n - 1, s);
      q.push_back(b);
    end
    sp();
  endtask
  // bounded poll: a stuck busy flag ends as a failure, not a hang
  task automatic poll(output logic ok);
    logic [7:0] q[$];
    ok = 1'b0;
    for (int k = 0; k < 16 && !ok; k++) begin
      rd(FRA_SUB_STATUS, 1, q);
      ok = (q[0][FRA_BUSY_BIT] === 1'b0);
    end
  endtask
  task automatic iw(input logic [15:0] a, input logic [15:0] d, output logic ok);
    logic k;
    poll(ok);
    wr(FRA_ADDR_WR, FRA_SUB_WR_ADDR, {a[15:8], a[7:0]});
    poll(k);
    wr(FRA_ADDR_WR, FRA_SUB_DATA, {d[15:8], d[7:0]});
    ok = ok & k;
  endtask
  task automatic ir(input logic [15:0] a, output logic [15:0] d, output logic ok);
    logic       k;
    logic [7:0] q[$];
    poll(ok);
    wr(FRA_ADDR_WR, FRA_SUB_RD_ADDR, {a[15:8], a[7:0]});
    poll(k);
    rd(FRA_SUB_DATA, 2, q);
    d = {q[0], q[1]};
    ok = ok & k;
  endtask
endmodule

// File: tb/testbench.sv
// testbench: scenarios for the i2c register access block
`timescale 1ns/1ps
module testbench;
  import fra_pkg::*;
  localparam int LIMIT = 30000;
  logic        clk_i;
  logic        rst_b_i = 1'b0;
  logic        scl;
  logic        sda;
  logic        sda_oe_b;
  logic [7:0]  pads;
  logic [7:0]  q[$];
  logic        ok;
  logic [15:0] w;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  fra_top #(.RAM_AW(6)) i_fra_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl),
    .sda_i(sda), .sda_oe_b_o(sda_oe_b), .output_pad_enables_o(pads));
  fra_host i_host (.clk_i(clk_i), .sda_oe_b_i(sda_oe_b), .scl_o(scl), .sda_o(sda));
  // ============================================================
  // clock, timeout, reporting
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h", $time, m, g);
    end
  endtask
  task automatic cmp1(input logic g, input logic e, input string m);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic do_reset();
    rst_b_i = 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
  endtask
  // ============================================================
  // scenarios
  task automatic t_power_up();
    cmp8(pads, FRA_PADS_RESET, "pads after reset");
    i_host.rd(FRA_SUB_MAKER, 1, q);
    cmp8(q[0], FRA_MAKER_ID, "maker id");
    i_host.rd(FRA_SUB_PADS, 1, q);
    cmp8(q[0], FRA_PADS_RESET, "pads register reset");
  endtask
  task automatic t_direct();
    i_host.wr(FRA_ADDR_WR, FRA_SUB_PADS, {8'ha5});
    cmp1(i_host.ack_a, 1'b1, "address ack");
    cmp8(pads, 8'ha5, "pads write");
    i_host.wr(FRA_ADDR_WR, FRA_SUB_PADS, {8'h3c});
    i_host.rd(FRA_SUB_PADS, 1, q);
    cmp8(q[0], 8'h3c, "pads readback");
    i_host.wr(FRA_ADDR_WR, 8'h10, {8'hff});
    i_host.wr(FRA_ADDR_WR, FRA_SUB_MAKER, {8'h11});
    i_host.rd(8'h10, 1, q);
    cmp8(q[0], FRA_ZERO_BYTE, "unmapped read");
    i_host.rd(FRA_SUB_MAKER, 1, q);
    cmp8(q[0], FRA_MAKER_ID, "maker read only");
    i_host.wr(8'h84, FRA_SUB_PADS, {8'hff});
    cmp1(i_host.ack_a, 1'b0, "foreign address acked");
    cmp8(pads, 8'h3c, "pads kept");
  endtask
  task automatic t_indirect();
    logic [15:0] a [2] = '{16'h0000, 16'h003f};
    logic [15:0] d [2] = '{16'hbeef, 16'h1234};
    for (int i = 0; i < 2; i++) begin
      i_host.iw(a[i], d[i], ok);
      cmp1(ok, 1'b1, "busy before write");
    end
    for (int i = 0; i < 2; i++) begin
      i_host.ir(a[i], w, ok);
      cmp1(ok, 1'b1, "busy before read");
      cmp8(w[15:8], d[i][15:8], "data high byte");
      cmp8(w[7:0], d[i][7:0], "data low byte");
    end
  endtask
  initial begin
    do_reset();
    t_power_up();
    t_direct();
    t_indirect();
    do_reset();
    t_power_up();
    finish_test();
  end
endmodule
